/* mmu_dp_model.sv */
// data path stand-in that drives the access port of the unit
// assumes the bench calls access() from its main sequence
`timescale 1ns/1ps

module mmu_dp_model (
  input  wire logic        i_mclk,
  output logic             o_valid,
  output logic [15:0]      o_va,
  output logic [1:0]       o_mode,
  output logic             o_write,
  output logic             o_ifetch,
  output logic [15:0]      o_pc
);
  initial begin
    o_valid = 1'b0;
    o_va = 16'h0000;
    o_mode = 2'h0;
    o_write = 1'b0;
    o_ifetch = 1'b0;
    o_pc = 16'h0000;
  end

  // one address cycle; va and pc lines then carry inverted values, mode and write hold theirs
  task automatic access(input logic [15:0] va, input logic [1:0] md,
                        input logic wr, input logic fe,
                        input logic [15:0] pc);
    @(posedge i_mclk);
    o_valid <= 1'b1;
    o_va <= va;
    o_mode <= md;
    o_write <= wr;
    o_ifetch <= fe;
    o_pc <= pc;
    @(posedge i_mclk);
    o_valid <= 1'b0;
    o_ifetch <= 1'b0;
    o_va <= ~va;
    o_pc <= ~pc;
    #1;
  endtask
endmodule

/* mmu_pkg.sv */
// constants for the memory management status and abort logic
// assumes a 16-bit processor data path and a classic wishbone slave port
package mmu_pkg;

  // --------------------------------------------------------------
  // register byte offsets
  // --------------------------------------------------------------
  localparam logic [7:0] OFS_ABORT_STATUS  = 8'h00;
  localparam logic [7:0] OFS_UNUSED_STATUS = 8'h04;
  localparam logic [7:0] OFS_FETCH_PC      = 8'h08;
  localparam logic [7:0] OFS_MAP_CONFIG    = 8'h0c;
  localparam logic [7:0] OFS_PAGE_BASE     = 8'h40;
  localparam logic [7:0] OFS_PAGE_DESC     = 8'h80;

  // --------------------------------------------------------------
  // abort status fields
  // --------------------------------------------------------------
  localparam int STS_NONRES  = 15;
  localparam int STS_LENGTH  = 14;
  localparam int STS_RDONLY  = 13;
  localparam int STS_MODE    = 5;
  localparam int STS_PAGE    = 1;
  localparam int STS_ENABLE  = 0;

  // --------------------------------------------------------------
  // map config fields
  // --------------------------------------------------------------
  localparam int CFG_PERIPH_MAP = 5;
  localparam int CFG_MAP22      = 4;

  // --------------------------------------------------------------
  // page descriptor fields
  // --------------------------------------------------------------
  localparam int DESC_LEN  = 8;
  localparam int DESC_DOWN = 3;
  localparam int DESC_KEY  = 1;
  localparam logic [1:0] KEY_NONRES = 2'h0;
  localparam logic [1:0] KEY_RDONLY = 2'h1;

  // --------------------------------------------------------------
  // reset values and sizes
  // --------------------------------------------------------------
  localparam logic [15:0] RST_REG16 = 16'h0000;
  localparam int NUM_PAGES = 16;
  localparam int VA_W      = 16;
  localparam int PA_W      = 22;

endpackage

/* mmu_status_abort.sv */
// memory management status, translation and abort detection
// assumes one 20 MHz clock, a wishbone classic master for software,
// and a data path that presents one address cycle per valid strobe
//
// Functional notes
// - translate 16-bit virtual address into 18-bit or 22-bit physical when enabled
// - sixteen page base and sixteen page descriptor registers
// - nonresident flag set when page access key is zero
// - illegal processor mode sets both nonresident and length flags
// - length flag set when block number exceeds page length field, or falls below it on downward pages
// - nonresident and length flags may set in one access
// - read-only flag set on write to page with key one
// - faulting page mode recorded in bits 6 to 5
// - faulting page number recorded in bits 3 to 1
// - enable bit one relocates; zero passes untranslated, no checks
// - unused status register reads zero, ignores writes
// - unused status register access completes without bus error
// - fetch pc capture loads pc on instruction fetch address cycles
// - fetch pc capture freezes once any abort flag set; read-only
// - config bit 5 enables optional peripheral map
// - config bit 4 selects 18-bit or 22-bit mapping
// - other config bits read zero
//
// The address map and the Wishbone register port were decided locally.
`timescale 1ns/1ps

module mmu_status_abort (
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  input  wire logic        i_ce,
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic      [31:0] o_wb_dat,
  output logic             o_wb_ack,
  input  wire logic        i_acc_valid,
  input  wire logic [15:0] i_acc_va,
  input  wire logic [1:0]  i_acc_mode,
  input  wire logic        i_acc_write,
  input  wire logic        i_acc_ifetch,
  input  wire logic [15:0] i_acc_pc,
  output logic      [21:0] o_pa,
  output logic             o_pa_valid,
  output logic             o_abort,
  output logic             o_periph_map_en,
  output logic             o_map22
);

  // ------------------------------------------------------------------
  // functions
  // ------------------------------------------------------------------
  function automatic logic [15:0] lane_merge(input logic [15:0] old_v,
                                             input logic [31:0] wd,
                                             input logic [3:0]  sel);
    logic [15:0] r;
    r = old_v;
    if (sel[0]) begin
      r[7:0] = wd[7:0];
    end
    if (sel[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction

  function automatic logic is_page(input logic [7:0] adr,
                                   input logic [7:0] base);
    return adr[7:6] == base[7:6];
  endfunction

  // ------------------------------------------------------------------
  // storage
  // ------------------------------------------------------------------
  logic [15:0] page_base_regs       [mmu_pkg::NUM_PAGES];
  logic [15:0] page_descriptor_regs [mmu_pkg::NUM_PAGES];
  logic [2:0]  flags_r;
  logic [1:0]  fault_mode_r;
  logic [2:0]  fault_page_r;
  logic        enable_r;
  logic [15:0] fetch_pc_r;
  logic        periph_r;
  logic        map22_r;
  logic        ack_r;
  logic [31:0] rdat_r;
  logic [21:0] pa_r;
  logic        pa_valid_r;
  logic        abort_r;

  // ------------------------------------------------------------------
  // access decode and checks
  // ------------------------------------------------------------------
  logic [3:0]  pg_idx;
  logic [15:0] pg_base;
  logic [15:0] pg_desc;
  logic [6:0]  blk;
  logic [6:0]  page_length_field;
  logic [1:0]  key;
  logic        illegal_mode;
  logic        chk;
  logic        f_nonres;
  logic        f_length;
  logic        f_rdonly;
  logic        fault;
  logic [21:0] pa_full;
  logic [21:0] pa_nxt;

  always_comb begin
    pg_idx  = {i_acc_mode[1], i_acc_va[15:13]};
    pg_base = page_base_regs[pg_idx];
    pg_desc = page_descriptor_regs[pg_idx];
    blk     = i_acc_va[12:6];
    page_length_field     = pg_desc[mmu_pkg::DESC_LEN +: 7];
    key     = pg_desc[mmu_pkg::DESC_KEY +: 2];
    illegal_mode = i_acc_mode[1] ^ i_acc_mode[0];
    chk      = i_acc_valid & enable_r;
    f_nonres = chk & (illegal_mode |
                      (key == mmu_pkg::KEY_NONRES));
    // length check applies in its own right so both flags can rise
    f_length = chk & (illegal_mode |
               (pg_desc[mmu_pkg::DESC_DOWN] ? (blk < page_length_field)
                                            : (blk > page_length_field)));
    f_rdonly = chk & i_acc_write & ~illegal_mode &
               (key == mmu_pkg::KEY_RDONLY);
    fault    = f_nonres | f_length | f_rdonly;
    pa_full  = {pg_base, 6'h00} + {9'h000, i_acc_va[12:0]};
    if (!enable_r) begin
      pa_nxt = {6'h00, i_acc_va};
    end else if (map22_r) begin
      pa_nxt = pa_full;
    end else begin
      pa_nxt = {4'h0, pa_full[17:0]};
    end
  end

  // ------------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------------
  logic bus_req;
  logic bus_wr;
  logic [3:0] reg_idx;

  // writes land on the ack edge so master and slave agree on timing
  assign bus_req  = i_wb_cyc & i_wb_stb;
  assign bus_wr   = bus_req & i_wb_we & ack_r;
  assign reg_idx  = i_wb_adr[5:2];
  assign o_wb_ack = ack_r;
  assign o_wb_dat = rdat_r;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ack_r <= 1'b0;
    end else if (i_ce) begin
      ack_r <= bus_req & ~ack_r;     // every address answers
    end
  end

  // ------------------------------------------------------------------
  // read data
  // ------------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdat_r <= 32'h0000_0000;
    end else if (i_ce) begin
      rdat_r <= 32'h0000_0000;       // unmapped and unused read zero
      if (bus_req & ~ack_r & ~i_wb_we) begin
        if (i_wb_adr == mmu_pkg::OFS_ABORT_STATUS) begin
          rdat_r[15:0] <= {flags_r, 6'h00, fault_mode_r, 1'b0,
                           fault_page_r, enable_r};
        end else if (i_wb_adr == mmu_pkg::OFS_FETCH_PC) begin
          rdat_r[15:0] <= fetch_pc_r;
        end else if (i_wb_adr == mmu_pkg::OFS_MAP_CONFIG) begin
          rdat_r[15:0] <= {10'h000, periph_r, map22_r, 4'h0};
        end else if (is_page(i_wb_adr, mmu_pkg::OFS_PAGE_BASE)) begin
          rdat_r[15:0] <= page_base_regs[reg_idx];
        end else if (is_page(i_wb_adr, mmu_pkg::OFS_PAGE_DESC)) begin
          rdat_r[15:0] <= page_descriptor_regs[reg_idx];
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // page registers
  // ------------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < mmu_pkg::NUM_PAGES; i++) begin
        page_base_regs[i]       <= mmu_pkg::RST_REG16;
        page_descriptor_regs[i] <= mmu_pkg::RST_REG16;
      end
    end else if (i_ce & bus_wr) begin
      if (is_page(i_wb_adr, mmu_pkg::OFS_PAGE_BASE)) begin
        page_base_regs[reg_idx] <=
          lane_merge(page_base_regs[reg_idx], i_wb_dat, i_wb_sel);
      end else if (is_page(i_wb_adr, mmu_pkg::OFS_PAGE_DESC)) begin
        page_descriptor_regs[reg_idx] <=
          lane_merge(page_descriptor_regs[reg_idx], i_wb_dat, i_wb_sel);
      end
    end
  end

  // ------------------------------------------------------------------
  // abort status
  // ------------------------------------------------------------------
  logic [15:0] sts_wr;
  assign sts_wr = lane_merge({flags_r, 6'h00, fault_mode_r, 1'b0,
                              fault_page_r, enable_r}, i_wb_dat, i_wb_sel);

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flags_r  <= 3'h0;
      enable_r <= 1'b0;
    end else if (i_ce) begin
      if (bus_wr && i_wb_adr == mmu_pkg::OFS_ABORT_STATUS) begin
        enable_r <= sts_wr[mmu_pkg::STS_ENABLE];
        // a fault in the same cycle as a clear still lands
        flags_r  <= sts_wr[15:13] |
                    {f_nonres, f_length, f_rdonly};
      end else begin
        flags_r  <= flags_r | {f_nonres, f_length, f_rdonly};
      end
    end
  end

  // first fault wins the record; later ones keep it stable for software
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fault_mode_r <= 2'h0;
      fault_page_r <= 3'h0;
    end else if (i_ce) begin
      if (bus_wr && i_wb_adr == mmu_pkg::OFS_ABORT_STATUS &&
          !fault) begin
        fault_mode_r <= sts_wr[mmu_pkg::STS_MODE +: 2];
        fault_page_r <= sts_wr[mmu_pkg::STS_PAGE +: 3];
      end else if (fault && flags_r == 3'h0) begin
        fault_mode_r <= i_acc_mode;
        fault_page_r <= i_acc_va[15:13];
      end
    end
  end

  // ------------------------------------------------------------------
  // fetch pc capture
  // ------------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fetch_pc_r <= mmu_pkg::RST_REG16;
    end else if (i_ce) begin
      if (i_acc_valid & i_acc_ifetch & (flags_r == 3'h0)) begin
        fetch_pc_r <= i_acc_pc;
      end
    end
  end

  // ------------------------------------------------------------------
  // map config
  // ------------------------------------------------------------------
  logic [15:0] cfg_wr;
  assign cfg_wr = lane_merge({10'h000, periph_r, map22_r, 4'h0},
                             i_wb_dat, i_wb_sel);
  assign o_periph_map_en = periph_r;
  assign o_map22         = map22_r;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      periph_r <= 1'b0;
      map22_r  <= 1'b0;
    end else if (i_ce) begin
      if (bus_wr && i_wb_adr == mmu_pkg::OFS_MAP_CONFIG) begin
        periph_r <= cfg_wr[mmu_pkg::CFG_PERIPH_MAP];
        map22_r  <= cfg_wr[mmu_pkg::CFG_MAP22];
      end
    end
  end

  // ------------------------------------------------------------------
  // physical address and abort outputs
  // ------------------------------------------------------------------
  assign o_pa       = pa_r;
  assign o_pa_valid = pa_valid_r;
  assign o_abort    = abort_r;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pa_r       <= 22'h00_0000;
      pa_valid_r <= 1'b0;
      abort_r    <= 1'b0;
    end else if (i_ce) begin
      pa_r       <= pa_nxt;
      pa_valid_r <= i_acc_valid & ~fault;
      abort_r    <= fault;
    end
  end

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_n);

  a_nonres_key_zero: assert property (
    i_ce && chk && key == 2'h0 |=> flags_r[2] && o_abort)
    else $error("nonresident flag not set");

  a_illegal_both_flags: assert property (
    i_ce && chk && (i_acc_mode == 2'h1 || i_acc_mode == 2'h2)
    |=> flags_r[2] && flags_r[1])
    else $error("illegal mode did not set both flags");

  a_length_outside: assert property (
    i_ce && chk && !pg_desc[3] && blk > page_length_field |=> flags_r[1])
    else $error("length flag not set");

  a_readonly_write: assert property (
    i_ce && chk && i_acc_write && !illegal_mode && key == 2'h1
    |=> flags_r[0])
    else $error("read-only flag not set");

  a_fault_page_rec: assert property (
    i_ce && fault && flags_r == 3'h0 && !bus_wr
    |=> fault_page_r == $past(i_acc_va[15:13])
        && fault_mode_r == $past(i_acc_mode))
    else $error("fault page or mode not recorded");

  a_passthru_off: assert property (
    i_ce && i_acc_valid && !enable_r
    |=> o_pa == {6'h00, $past(i_acc_va)} && o_pa_valid && !o_abort)
    else $error("disabled unit altered address");

  a_unused_zero: assert property (
    i_ce && bus_req && !ack_r && !i_wb_we
    && i_wb_adr == mmu_pkg::OFS_UNUSED_STATUS
    |=> o_wb_ack && o_wb_dat == 32'h0000_0000)
    else $error("unused status not zero");

  a_pc_load: assert property (
    i_ce && i_acc_valid && i_acc_ifetch && flags_r == 3'h0
    |=> fetch_pc_r == $past(i_acc_pc))
    else $error("fetch pc not captured");

  a_pc_frozen: assert property (
    flags_r != 3'h0 ##1 flags_r != 3'h0 |-> $stable(fetch_pc_r))
    else $error("fetch pc changed after abort");

  a_cfg_zero_bits: assert property (
    o_wb_ack && !i_wb_we && i_wb_adr == mmu_pkg::OFS_MAP_CONFIG
    |-> o_wb_dat[31:6] == 26'h0 && o_wb_dat[3:0] == 4'h0)
    else $error("config reserved bits nonzero");

  a_abort_suppress: assert property (
    o_abort |-> !o_pa_valid)
    else $error("aborted access reached memory");

  a_ack_single: assert property (
    i_ce && o_wb_ack |=> !o_wb_ack)
    else $error("ack held more than one cycle");

  a_map18_upper: assert property (
    i_ce && !map22_r |=> o_pa[21:18] == 4'h0)
    else $error("narrow map drove upper address bits");

  a_status_write: assert property (
    i_ce && bus_wr && i_wb_adr == mmu_pkg::OFS_ABORT_STATUS
    && i_wb_sel[1:0] == 2'h3 && !fault
    |=> flags_r == $past(i_wb_dat[15:13])
        && enable_r == $past(i_wb_dat[0]))
    else $error("status write did not land");

  // a low enable must hold the flags, fetch pc, ack and physical address registers
  a_ce_freeze: assert property (
    !i_ce |=> $stable(flags_r) && $stable(fetch_pc_r)
              && $stable(ack_r) && $stable(pa_r))
    else $error("state moved while clock enable low");

endmodule

/* mmu_status_abort_tb.sv */
// self-checking bench for the memory management status and abort logic
// assumes mmu_pkg, the design and mmu_dp_model are compiled first
`timescale 1ns/1ps

module mmu_status_abort_tb;
  logic        i_mclk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic        cyc = 1'b0;
  logic        ce = 1'b1;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0, rd, o_wb_dat;
  logic [21:0] o_pa;
  logic        o_wb_ack, o_pa_valid, o_abort, o_periph_map_en, o_map22;
  logic        a_valid, a_write, a_ifetch;
  logic [15:0] a_va, a_pc;
  logic [1:0]  a_mode;
  int n_fail = 0, num_checks = 0, seed = 86, pg;
  int base[16], desc[16], sts = 0, cfg = 0, pcap = 0;
  logic [7:0] ro_ofs[3] = '{8'h04, 8'h08, 8'h3c};
  int tva[8] = '{32'h4000, 32'h6180, 32'h6100, 32'ha000,
                 32'ha000, 32'h2000, 32'h2000, 32'he0c0};
  int tmd[8] = '{0, 3, 3, 3, 3, 1, 2, 0};
  int twr[8] = '{0, 0, 0, 1, 0, 0, 0, 0};
  int tds[8] = '{32'h7f00, 32'h0504, 32'h050c, 32'h7f02,
                 32'h7f02, 32'h7f04, 32'h7f04, 32'h0200};

  always #25 i_mclk = ~i_mclk;

  mmu_status_abort i_mmu_status_abort (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(ce),
    .i_wb_cyc(cyc), .i_wb_stb(cyc), .i_wb_we(we), .i_wb_adr(adr),
    .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(o_wb_dat),
    .o_wb_ack(o_wb_ack), .i_acc_valid(a_valid), .i_acc_va(a_va),
    .i_acc_mode(a_mode), .i_acc_write(a_write),
    .i_acc_ifetch(a_ifetch), .i_acc_pc(a_pc), .o_pa(o_pa),
    .o_pa_valid(o_pa_valid), .o_abort(o_abort),
    .o_periph_map_en(o_periph_map_en), .o_map22(o_map22));

  mmu_dp_model i_mmu_dp_model (
    .i_mclk(i_mclk), .o_valid(a_valid), .o_va(a_va), .o_mode(a_mode),
    .o_write(a_write), .o_ifetch(a_ifetch), .o_pc(a_pc));

  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string m);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  // ack sampled at the rising edge; data taken and request dropped there
  task automatic wb_cycle(input logic [7:0] a, input logic w,
                          input logic [31:0] d, input logic [3:0] s);
    @(posedge i_mclk);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do @(posedge i_mclk); while (o_wb_ack !== 1'b1);
    rd = o_wb_dat;
    cyc <= 1'b0;
    we <= 1'b0;
  endtask

  // fault software looks only at the highest flag that is set
  function automatic int top_flag(input logic [31:0] s);
    if ($isunknown(s)) return -1;
    if (s[15]) return 15;
    if (s[14]) return 14;
    if (s[13]) return 13;
    return 0;
  endfunction

  task automatic wb_write(input logic [7:0] a, input int d,
                          input logic [3:0] s);
    int m;
    m = (s[0] ? 32'h00ff : 32'h0) | (s[1] ? 32'hff00 : 32'h0);
    wb_cycle(a, 1'b1, d, s);
    if (a == mmu_pkg::OFS_ABORT_STATUS)
      sts = ((sts & ~m) | (d & m)) & 32'he06f;
    if (a == mmu_pkg::OFS_MAP_CONFIG)
      cfg = ((cfg & ~m) | (d & m)) & 32'h0030;
    if (a[7:6] == 2'h1) base[a[5:2]] = d & 32'hffff;
    if (a[7:6] == 2'h2) desc[a[5:2]] = d;
  endtask

  task automatic chk_reg(input logic [7:0] a, input int e);
    wb_cycle(a, 1'b0, 32'h0, 4'h3);
    chk(rd, e, "register read");
  endtask

  // -----------------------------------------------------------
  // reference model of one access
  // -----------------------------------------------------------
  task automatic acc(input int va, input int md, input int wr,
                     input int fe, input int pc);
    int p, blk, len, k, fl, pa;
    va &= 32'hffff;
    pc &= 32'hffff;
    p = ((md >> 1) & 1) * 8 + ((va >> 13) & 7);
    blk = (va >> 6) & 127;
    len = (desc[p] >> 8) & 127;
    k = (desc[p] >> 1) & 3;
    fl = 0;
    pa = va;
    if (sts & 1) begin
      if (md == 1 || md == 2) fl = 6;
      else begin
        if (k == 0) fl = 4;
        if ((desc[p] & 8) ? blk < len : blk > len) fl |= 2;
        if (k == 1 && wr) fl |= 1;
      end
      pa = (base[p] * 64 + (va & 8191)) & 32'h3fffff;
      if (!(cfg & 16)) pa &= 32'h3ffff;
    end
    if (fe && !(sts & 32'he000)) pcap = pc;
    if (fl && !(sts & 32'he000))
      sts = (sts & 32'he001) | (md << 5) | (((va >> 13) & 7) << 1);
    sts |= fl << 13;
    i_mmu_dp_model.access(va[15:0], md[1:0], wr[0], fe[0], pc[15:0]);
    chk(o_abort, fl != 0, "abort pulse");
    chk(o_pa_valid, fl == 0, "cycle allowed");
    if (fl == 0) chk(o_pa, pa, "physical address");
  endtask

  task automatic chk_cfg;
    chk_reg(mmu_pkg::OFS_MAP_CONFIG, cfg);
    chk(o_periph_map_en, (cfg >> 5) & 1, "peripheral map");
    chk(o_map22, (cfg >> 4) & 1, "map width");
  endtask

  task automatic report_and_stop;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    chk_reg(mmu_pkg::OFS_ABORT_STATUS, 0);
    chk_cfg();
    foreach (ro_ofs[i]) begin
      wb_write(ro_ofs[i], 32'hffff, 4'h3);
      chk_reg(ro_ofs[i], 0);
    end
    $display("test reset and read-only done");
    wb_write(mmu_pkg::OFS_MAP_CONFIG, 32'hff30, 4'h1);
    chk_cfg();
    wb_write(mmu_pkg::OFS_MAP_CONFIG, 32'h0010, 4'h2);
    chk_cfg();
    wb_write(mmu_pkg::OFS_MAP_CONFIG, 32'h0010, 4'h3);
    chk_cfg();
    $display("test map config done");
    repeat (4) acc($random(seed), 3, 0, 1, $random(seed));
    // clock enable low: the unit must ignore a fetch entirely
    @(posedge i_mclk);
    ce <= 1'b0;
    i_mmu_dp_model.access(16'h1234, 2'h3, 1'b0, 1'b1, 16'hbeef);
    chk(o_pa_valid, 0, "frozen cycle allowed");
    chk(o_abort, 0, "frozen cycle aborted");
    @(posedge i_mclk);
    ce <= 1'b1;
    chk_reg(mmu_pkg::OFS_FETCH_PC, pcap);
    $display("test relocation off done");
    for (int p = 0; p < 16; p++) begin
      wb_write(8'(mmu_pkg::OFS_PAGE_BASE + 4 * p), $random(seed), 4'h3);
      chk_reg(8'(mmu_pkg::OFS_PAGE_BASE + 4 * p), base[p]);
      wb_write(8'(mmu_pkg::OFS_PAGE_DESC + 4 * p), 32'h7f04 | (p & 1) << 1,
               4'h3);
    end
    wb_write(mmu_pkg::OFS_ABORT_STATUS, 32'h0001, 4'h3);
    // second round runs with the narrow map width
    repeat (2) begin
      repeat (12) acc($random(seed), ($random(seed) & 1) * 3,
                      $random(seed) & 1, 0, 0);
      wb_write(mmu_pkg::OFS_MAP_CONFIG, 32'h0000, 4'h3);
    end
    $display("test translation done");
    for (int i = 0; i < 8; i++) begin
      pg = ((tmd[i] >> 1) & 1) * 8 + ((tva[i] >> 13) & 7);
      wb_write(8'(mmu_pkg::OFS_PAGE_DESC + 4 * pg), tds[i], 4'h3);
      wb_write(mmu_pkg::OFS_ABORT_STATUS, 32'h0001, 4'h3);
      acc(tva[i], tmd[i], twr[i], 1, 32'h1000 + i);
      acc(32'h0040, 0, 0, 1, 32'h2000 + i);
      chk_reg(mmu_pkg::OFS_ABORT_STATUS, sts);
      chk(top_flag(rd), top_flag(sts), "abort cause");
      chk_reg(mmu_pkg::OFS_FETCH_PC, pcap);
    end
    wb_write(mmu_pkg::OFS_ABORT_STATUS, 32'h0000, 4'h3);
    chk_reg(mmu_pkg::OFS_ABORT_STATUS, 0);
    $display("test aborts done");
    report_and_stop();
  end

  // generous bound; the sequence needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge i_mclk);
    n_fail++;
    report_and_stop();
  end
endmodule
